// ---- alias_remapper.sv ----
// Remote target alias remapper: APB register file of target/alias pairs
// and the translation of incoming I2C target addresses.
// Assumes the local I2C decoder and the control channel run on pclk.
//
// Behaviour
// [R1] Target register holds 7-bit address, resets zero
// [R2] Alias hit substitutes target address before forwarding
// [R3] Alias field bits 7:1 compared with incoming address
// [R4] Alias zero maps to target register zero
// [R5] Zero alias disables its path
// [R6] Auto-ack bit acknowledges writes without remote answer
// [R7] Software keeps auto-ack cleared except when debugging
// [R8] Alias resets zero, auto-ack bit resets cleared
// [R9] Every alias pairs with equal-index target
// [R10] Unmatched address is neither remapped nor forwarded
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps

module alias_remapper (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    input wire logic [6:0] req_addr,
    input wire logic req_write,
    output logic fwd_valid,
    output logic [6:0] fwd_addr,
    output logic fwd_write,
    output logic [2:0] fwd_index,
    output logic auto_ack,
    output logic miss
);

    typedef struct packed {
        logic [remap_pkg::NUM_PAIRS-1:0][remap_pkg::ADDR_W-1:0] tgt;
        logic [remap_pkg::NUM_PAIRS-1:0][remap_pkg::ADDR_W-1:0] alias_id;
        logic [remap_pkg::NUM_PAIRS-1:0] aack;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic fwd_valid;
        logic [remap_pkg::ADDR_W-1:0] fwd_addr;
        logic fwd_write;
        logic [remap_pkg::IDX_W-1:0] fwd_index;
        logic auto_ack;
        logic miss;
        logic last_hit;
        logic [remap_pkg::IDX_W-1:0] last_idx;
        logic last_aack;
        logic last_miss;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic [remap_pkg::NUM_PAIRS-1:0] alias_hit;
    logic any_hit;
    logic [remap_pkg::IDX_W-1:0] hit_idx;
    logic [remap_pkg::ADDR_W-1:0] hit_tgt;
    logic [7:0] reg_idx;
    logic word_ok;
    logic is_tgt;
    logic is_alias;
    logic is_status;
    logic mapped;
    logic [remap_pkg::IDX_W-1:0] sel;
    logic setup;
    logic wr_access;

    // Decoder: one comparator per alias
    genvar g;
    generate
        for (g = 0; g < remap_pkg::NUM_PAIRS; g++)
        begin : g_match
            alias_pair_match #(
                .W(remap_pkg::ADDR_W)
            ) u_match (
                .alias_id(state_reg.alias_id[g]), // [R3] [R5]
                .addr(req_addr),
                .hit(alias_hit[g])
            );
        end
    endgenerate

    // Lowest index wins if software programs two equal aliases
    function automatic logic [remap_pkg::IDX_W-1:0] first_hit(
        input logic [remap_pkg::NUM_PAIRS-1:0] hits
    );
        logic [remap_pkg::IDX_W-1:0] idx;
        idx = '0;
        for (int i = remap_pkg::NUM_PAIRS - 1; i >= 0; i--)
        begin
            if (hits[i])
            begin
                idx = remap_pkg::IDX_W'(i);
            end
        end
        return idx;
    endfunction

    assign any_hit = |alias_hit;
    assign hit_idx = first_hit(alias_hit);
    assign hit_tgt = state_reg.tgt[hit_idx]; // [R9]

    // APB decode; reg_idx is the word index
    assign reg_idx = paddr[9:2];
    assign word_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign is_tgt = word_ok
        && (reg_idx >= remap_pkg::REMOTE_TARGET_ADDR_0_IDX)
        && (reg_idx <= remap_pkg::REMOTE_TARGET_ADDR_7_IDX);
    assign is_alias = word_ok
        && (reg_idx >= remap_pkg::TARGET_ALIAS_0_IDX)
        && (reg_idx <= remap_pkg::TARGET_ALIAS_7_IDX);
    assign is_status = word_ok && (reg_idx == remap_pkg::REMAP_STATUS_IDX);
    assign mapped = is_tgt || is_alias || is_status;
    assign sel = is_tgt
        ? remap_pkg::IDX_W'(reg_idx - remap_pkg::REMOTE_TARGET_ADDR_0_IDX)
        : remap_pkg::IDX_W'(reg_idx - remap_pkg::TARGET_ALIAS_0_IDX);
    assign setup = psel && !penable;
    assign wr_access = psel && penable && state_reg.pready && pwrite;

    always_comb
    begin
        logic [31:0] rd;
        rd = '0;
        state_next = state_reg;

        // Registers answer with zero wait states
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        if (is_tgt)
        begin
            rd[remap_pkg::FIELD_HI:remap_pkg::FIELD_LO] =
                state_reg.tgt[sel]; // [R1]
        end
        else if (is_alias)
        begin
            rd[remap_pkg::FIELD_HI:remap_pkg::FIELD_LO] =
                state_reg.alias_id[sel]; // [R3]
            rd[remap_pkg::AUTO_ACK_BIT] = state_reg.aack[sel]; // [R8]
        end
        else if (is_status)
        begin
            rd[remap_pkg::ST_HIT_BIT] = state_reg.last_hit;
            rd[remap_pkg::ST_IDX_LO +: remap_pkg::IDX_W] =
                state_reg.last_idx;
            rd[remap_pkg::ST_AACK_BIT] = state_reg.last_aack;
            rd[remap_pkg::ST_MISS_BIT] = state_reg.last_miss;
        end
        if (setup)
        begin
            state_next.pready = 1'b1;
            state_next.pslverr = !mapped;
            state_next.prdata = pwrite ? 32'h0000_0000 : rd;
        end

        // Writes land at the completing access edge only
        if (wr_access && is_tgt)
        begin
            state_next.tgt[sel] =
                pwdata[remap_pkg::FIELD_HI:remap_pkg::FIELD_LO]; // [R1]
        end
        if (wr_access && is_alias)
        begin
            state_next.alias_id[sel] =
                pwdata[remap_pkg::FIELD_HI:remap_pkg::FIELD_LO]; // [R3]
            state_next.aack[sel] = pwdata[remap_pkg::AUTO_ACK_BIT]; // [R6]
        end

        // Translation uses the table as it stood before any same-edge write
        state_next.fwd_valid = 1'b0;
        state_next.auto_ack = 1'b0;
        state_next.miss = 1'b0;
        if (req_valid && any_hit)
        begin
            state_next.fwd_valid = 1'b1;
            state_next.fwd_addr = hit_tgt; // [R2] [R4] [R9]
            state_next.fwd_write = req_write;
            state_next.fwd_index = hit_idx;
            // Local ack ignores link lock and the remote answer
            state_next.auto_ack = req_write && state_reg.aack[hit_idx]; // [R6]
            state_next.last_hit = 1'b1;
            state_next.last_idx = hit_idx;
            state_next.last_aack = req_write && state_reg.aack[hit_idx];
            state_next.last_miss = 1'b0;
        end
        else if (req_valid)
        begin
            // Other logic owns unmatched traffic
            state_next.miss = 1'b1; // [R10]
            state_next.last_hit = 1'b0;
            state_next.last_aack = 1'b0;
            state_next.last_miss = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;
            state_reg.tgt <= {remap_pkg::NUM_PAIRS{remap_pkg::ADDR_RST}};
            state_reg.alias_id <=
                {remap_pkg::NUM_PAIRS{remap_pkg::ADDR_RST}}; // [R8]
            state_reg.aack <=
                {remap_pkg::NUM_PAIRS{remap_pkg::AUTO_ACK_RST}}; // [R8]
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign fwd_valid = state_reg.fwd_valid;
    assign fwd_addr = state_reg.fwd_addr;
    assign fwd_write = state_reg.fwd_write;
    assign fwd_index = state_reg.fwd_index;
    assign auto_ack = state_reg.auto_ack;
    assign miss = state_reg.miss;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_tgt_write;
        psel && penable && pready && pwrite && is_tgt;
    endsequence

    sequence s_alias_write;
        psel && penable && pready && pwrite && is_alias;
    endsequence

    sequence s_hit_req;
        req_valid && any_hit;
    endsequence

    AST_TGT_WRITE: assert property (s_tgt_write |=> // [R1]
        state_reg.tgt[$past(sel)] == $past(pwdata[7:1]))
        else $error("target address write not stored");

    AST_TGT_RSVD_ZERO: assert property ( // [R1]
        s_setup ##0 (!pwrite && is_tgt) |=> pready && prdata[0] == 1'b0)
        else $error("target register bit zero not zero");

    AST_HIT_FORWARD: assert property (s_hit_req |=> // [R2]
        fwd_valid && fwd_addr == $past(hit_tgt)
        && fwd_write == $past(req_write))
        else $error("alias hit not forwarded with target address");

    AST_ALIAS_WRITE: assert property (s_alias_write |=> // [R3]
        state_reg.alias_id[$past(sel)] == $past(pwdata[7:1])
        && state_reg.aack[$past(sel)] == $past(pwdata[0]))
        else $error("alias write not stored");

    AST_ALIAS0_PAIR: assert property ( // [R4]
        req_valid && alias_hit[0] |=> fwd_valid && fwd_index == 3'h0
        && fwd_addr == $past(state_reg.tgt[0]))
        else $error("alias zero not paired with target zero");

    AST_ZERO_ALIAS_OFF: assert property ( // [R5]
        req_valid && req_addr == remap_pkg::ALIAS_OFF |=> !fwd_valid && miss)
        else $error("zero address reached a remote path");

    AST_AUTO_ACK: assert property ( // [R6]
        s_hit_req ##0 (req_write && state_reg.aack[hit_idx])
        |=> auto_ack && fwd_valid)
        else $error("auto acknowledge missing");

    AST_AUTO_ACK_CAUSE: assert property ( // [R6]
        auto_ack |-> $past(req_valid && any_hit) && $past(req_write)
        && $past(state_reg.aack[hit_idx]))
        else $error("auto acknowledge without cause");

    AST_PAIR_INDEX: assert property (s_hit_req |=> // [R9]
        fwd_index == $past(hit_idx))
        else $error("forwarded index differs from alias index");

    AST_MISS: assert property ( // [R10]
        req_valid && !any_hit |=> miss && !fwd_valid && !auto_ack)
        else $error("unmatched address was forwarded");

    AST_UNMAPPED: assert property ( // [R1]
        s_setup ##0 !mapped |=> pready && pslverr)
        else $error("unmapped access without error");

    AST_RESET_CLEAR: assert property ($rose(presetn) |-> // [R1] [R8]
        state_reg.tgt == '0 && state_reg.alias_id == '0
        && state_reg.aack == '0)
        else $error("pair table not cleared by reset");

endmodule

// ---- remap_pkg.sv ----
// Constants for the remote target alias remapper: register indices,
// field positions and reset values.
// Assumes APB byte addresses are four times the register index.
package remap_pkg;

    localparam int NUM_PAIRS = 8;
    localparam int ADDR_W = 7;
    localparam int IDX_W = 3;

    // Register indices as printed; byte address is index times four
    localparam logic [7:0] REMOTE_TARGET_ADDR_0_IDX = 8'h39;
    localparam logic [7:0] REMOTE_TARGET_ADDR_4_IDX = 8'h3D;
    localparam logic [7:0] REMOTE_TARGET_ADDR_5_IDX = 8'h3E;
    localparam logic [7:0] REMOTE_TARGET_ADDR_6_IDX = 8'h3F;
    localparam logic [7:0] REMOTE_TARGET_ADDR_7_IDX = 8'h40;
    localparam logic [7:0] TARGET_ALIAS_0_IDX = 8'h41;
    localparam logic [7:0] TARGET_ALIAS_7_IDX = 8'h48;
    localparam logic [7:0] REMAP_STATUS_IDX = 8'h49;

    // Field layout of both register kinds
    localparam int FIELD_HI = 7;
    localparam int FIELD_LO = 1;
    localparam int AUTO_ACK_BIT = 0;

    // Status register layout
    localparam int ST_HIT_BIT = 0;
    localparam int ST_IDX_LO = 1;
    localparam int ST_AACK_BIT = 4;
    localparam int ST_MISS_BIT = 5;

    localparam logic [6:0] ADDR_RST = 7'h00;
    localparam logic AUTO_ACK_RST = 1'b0;
    localparam logic [6:0] ALIAS_OFF = 7'h00;

endpackage

// ---- alias_pair_match.sv ----
// One alias comparator of the remapper's address decoder.
// Assumes the alias and address come from the same clock domain.
`timescale 1ns/100ps

module alias_pair_match #(
    parameter int W = 7
) (
    input wire logic [W-1:0] alias_id,
    input wire logic [W-1:0] addr,
    output logic hit
);

    // A zero alias never matches, so the path stays closed
    assign hit = (alias_id != W'(0)) && (alias_id == addr);

endmodule

// ---- i2c_host_model.sv ----
// Local I2C host side of the alias remapper: issues decoded target
// addresses, one pulse per transaction, on pclk.
// Assumes the testbench calls send and observes the forwarded side.
`timescale 1ns/100ps

module i2c_host_model (
    input wire logic pclk,
    output logic req_valid,
    output logic [6:0] req_addr,
    output logic req_write
);
    initial
    begin
        req_valid = 1'b0;
        req_addr = 7'h55;
        req_write = 1'b0;
    end

    task automatic send(input logic [6:0] a, input logic wr);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_addr <= a;
        req_write <= wr;
        @(posedge pclk);
        req_valid <= 1'b0;
        // Idle lines not held, so a stale match would show
        req_addr <= ~a;
        req_write <= ~wr;
    endtask
endmodule

// ---- tb_alias_remapper.sv ----
// Self-checking bench of the alias remapper: APB master, host model,
// seeded random table contents and corner cases.
// Assumes zero APB wait states and a one-cycle translation.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end

module tb_alias_remapper;
    localparam logic [7:0] T0 = remap_pkg::REMOTE_TARGET_ADDR_0_IDX;
    localparam logic [7:0] A0 = remap_pkg::TARGET_ALIAS_0_IDX;
    localparam logic [7:0] ST = remap_pkg::REMAP_STATUS_IDX;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, req_valid, req_write, fwd_valid, fwd_write;
    logic auto_ack, miss;
    logic [6:0] req_addr, fwd_addr, a_miss;
    logic [2:0] fwd_index, n;
    logic [6:0] tgt [8];
    logic [6:0] als [8];
    int failures = 0;
    int total_checks = 0;
    int seed = 71;

    always #20 pclk = ~pclk;

    alias_remapper DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
        .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .fwd_write(fwd_write),
        .fwd_index(fwd_index), .auto_ack(auto_ack), .miss(miss));

    i2c_host_model HOST (.pclk(pclk), .req_valid(req_valid),
        .req_addr(req_addr), .req_write(req_write));

    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        int waits;
        waits = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        do
        begin
            @(posedge pclk);
            waits++;
        end
        while (pready !== 1'b1);
        // Slave answers in the first access cycle
        `CHK(waits, 1)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp,
                          input logic exp_err);
        apb(1'b0, idx, 32'h0);
        `CHK(rd, exp)
        `CHK(err, exp_err)
    endtask

    function automatic logic [31:0] st_word(input logic h,
                                            input logic [2:0] k,
                                            input logic a,
                                            input logic m);
        st_word = '0;
        st_word[remap_pkg::ST_HIT_BIT] = h;
        st_word[remap_pkg::ST_IDX_LO +: 3] = k;
        st_word[remap_pkg::ST_AACK_BIT] = a;
        st_word[remap_pkg::ST_MISS_BIT] = m;
    endfunction

    task automatic xlate(input logic [6:0] a, input logic wr,
                         input logic hit, input logic [2:0] k,
                         input logic ack);
        HOST.send(a, wr);
        @(negedge pclk);
        `CHK(fwd_valid, hit)
        `CHK(miss, ~hit)
        `CHK(auto_ack, ack)
        if (hit)
        begin
            `CHK(fwd_addr, tgt[k])
            `CHK(fwd_index, k)
            `CHK(fwd_write, wr)
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #2_000_000;
        failures++;
        wrap_up();
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            rd_chk(T0 + 8'(i), 32'h0, 1'b0);
            rd_chk(A0 + 8'(i), 32'h0, 1'b0);
        end
        for (int i = 0; i < 8; i++)
        begin
            tgt[i] = 7'($random(seed));
            als[i] = {1'b1, 3'($random(seed)), 3'(i)};
            // Upper write bits are junk and must not stick
            apb(1'b1, T0 + 8'(i), {24'($random(seed)), tgt[i], 1'b1});
            apb(1'b1, A0 + 8'(i), {24'h0, als[i], 1'b0});
            rd_chk(T0 + 8'(i), {24'h0, tgt[i], 1'b0}, 1'b0);
            rd_chk(A0 + 8'(i), {24'h0, als[i], 1'b0}, 1'b0);
        end
        repeat (24)
        begin
            n = 3'($random(seed));
            xlate(als[n], 1'($random(seed)), 1'b1, n, 1'b0);
        end
        a_miss = {1'b0, 6'($random(seed)) | 6'h01};
        xlate(a_miss, 1'b1, 1'b0, 3'h0, 1'b0);
        apb(1'b1, 8'h50, 32'h000000FF);
        `CHK(err, 1'b1)
        rd_chk(8'h50, 32'h0, 1'b1);
        // Auto-ack set for this debug pass only
        apb(1'b1, A0, {24'h0, als[0], 1'b1});
        rd_chk(A0, {24'h0, als[0], 1'b1}, 1'b0);
        xlate(als[0], 1'b1, 1'b1, 3'h0, 1'b1);
        rd_chk(ST, st_word(1'b1, 3'h0, 1'b1, 1'b0), 1'b0);
        xlate(als[0], 1'b0, 1'b1, 3'h0, 1'b0);
        apb(1'b1, A0, {24'h0, als[0], 1'b0});
        xlate(als[0], 1'b1, 1'b1, 3'h0, 1'b0);
        apb(1'b1, A0 + 8'h03, 32'h0);
        xlate(als[3], 1'b1, 1'b0, 3'h0, 1'b0);
        xlate(7'h00, 1'b1, 1'b0, 3'h0, 1'b0);
        // Status ignores writes and reports the last miss
        apb(1'b1, ST, 32'hFFFFFFFF);
        `CHK(err, 1'b0)
        rd_chk(ST, st_word(1'b0, 3'h0, 1'b0, 1'b1), 1'b0);
        // Second reset mid-run must clear a programmed table
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(T0 + 8'h01, 32'h0, 1'b0);
        rd_chk(A0 + 8'h01, 32'h0, 1'b0);
        xlate(als[1], 1'b1, 1'b0, 3'h0, 1'b0);
        wrap_up();
    end
endmodule
